// ### pkg/lprs_regs.svh
// Constants for the low-power and restore sequencer
`ifndef LPRS_REGS_SVH
`define LPRS_REGS_SVH
`define LPRS_CLK_HZ 40000000
`define LPRS_DS_WAKE_US 3000
`define LPRS_DS_WAKE_CYC ((`LPRS_DS_WAKE_US * 40) - 1)
`define LPRS_DS_MAX_S 22
`define LPRS_DS_MAX_CYC (`LPRS_DS_MAX_S * `LPRS_CLK_HZ)
`define LPRS_HIB_WAKE_MS 50
`define LPRS_HIB_WAKE_CYC (`LPRS_HIB_WAKE_MS * 40000)
`define LPRS_SHD_WAKE_MS 1100
`define LPRS_SHD_WAKE_CYC (`LPRS_SHD_WAKE_MS * 40000)
`define LPRS_RST_MS 8000
`define LPRS_RST_CYC (`LPRS_RST_MS * 40000)
`define LPRS_IDLE_CYC 1000
`define LPRS_STRAP_RESTORE 3'b110
`define LPRS_PROT_SECTOR 8'h00
`endif

// ### pkg/lprs_pkg.sv
// Types for the low-power and restore sequencer
package lprs_pkg;
    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b011,
        ST_HIB = 3'b100,
        ST_SHUT = 3'b101,
        ST_RESTORE = 3'b110
    } lprs_state_type;
    typedef enum logic [1:0] {
        RM_NONE = 2'b00,
        RM_PARAMS = 2'b01,
        RM_IMAGE = 2'b10
    } lprs_restore_type;
endpackage

// ### verilog/lprs_timer.sv
// Down-counting delay timer used by the sequencer
`timescale 1ns/10ps
`default_nettype none
module lprs_timer #(
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    output logic done
);
    logic [WIDTH-1:0] count; // Remaining cycles
    logic [WIDTH-1:0] next_count;
    logic next_done;
    // Next count and done pulse
    always_comb
    begin
        next_count = count;
        next_done = 1'b0;
        if (load)
        begin
            next_count = loadValue;
        end
        else if (count != '0)
        begin
            next_count = count - 1'b1;
            next_done = (count == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
    // Register stage
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            count <= '0;
            done <= 1'b0;
        end
        else
        begin
            count <= next_count;
            done <= next_done;
        end
    end
endmodule
`default_nettype wire

// ### verilog/lprs_sequencer.sv
// Power-state and factory-restore sequencer top level
// How it works
// - Idle for a while enters deep sleep unprompted
// - Timer or host command wakes within 3 ms
// - Context retention asserted through deep sleep
// - No host handshake for deep sleep
// - Extended sleep timer allows up to 22 s
// - Hibernate gates logic power, keeps clock on
// - Wake line brings hibernate out in 50 ms
// - Shutdown kills all power, 1.1 s wake
// - Three restore modes: none, params, image
// - Restore resumes after power loss, about 8 s
// - Protected factory sector denied to host
`timescale 1ns/10ps
`default_nettype none
`include "lprs_regs.svh"
module lprs_sequencer #(
    parameter int unsigned IDLE_CYC = `LPRS_IDLE_CYC,
    parameter int unsigned DS_MAX_CYC = `LPRS_DS_MAX_CYC,
    parameter int unsigned HIB_WAKE_CYC = `LPRS_HIB_WAKE_CYC,
    parameter int unsigned SHD_WAKE_CYC = `LPRS_SHD_WAKE_CYC,
    parameter int unsigned RST_CYC = `LPRS_RST_CYC,
    parameter int unsigned DS_WAKE_CYC = `LPRS_DS_WAKE_CYC
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reset_line_n,
    input wire logic sleep_wake_line_n,
    input wire logic [2:0] boot_strap_pins,
    input wire logic hostCmd,
    input wire logic activity,
    input wire logic extSleepEn,
    input wire logic [31:0] sleepCycles,
    input wire logic hibReq,
    input wire logic shutReq,
    input wire logic powerOn,
    input wire logic [1:0] restoreSel,
    input wire logic restorePending,
    input wire logic hostFlashReq,
    input wire logic [7:0] hostFlashSector,
    output logic [2:0] powerState,
    output logic digitalPowerOn,
    output logic rtcOn,
    output logic retainContext,
    output logic ready,
    output logic restoreBusy,
    output logic restorePendingSet,
    output logic [1:0] restoreMode,
    output logic hostFlashGrant,
    output logic hostFlashDenied
);
    lprs_pkg::lprs_state_type state, next_state; // Main sequencer state
    logic [31:0] idleCount, next_idleCount; // Inactivity counter
    logic resetLineQ, next_resetLineQ; // Previous reset line level
    logic [2:0] strapLatch, next_strapLatch; // Straps caught at release
    logic [1:0] next_restoreMode;
    logic next_restoreBusy, next_restorePendingSet;
    logic next_digitalPowerOn, next_rtcOn, next_retainContext, next_ready;
    logic next_grant, next_denied;
    logic tmrLoad; // Reload of the shared delay timer
    logic [31:0] tmrValue; // Value loaded into the timer
    logic tmrDone; // Timer expiry pulse
    logic resetRise; // Reset line released this cycle
    logic [31:0] sleepLimit; // Deep-sleep length clamped to limit

    // Shared delay timer
    lprs_timer #(.WIDTH(32)) u_timer (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(tmrLoad),
        .loadValue(tmrValue),
        .done(tmrDone)
    );

    // Sector is the protected factory area
    function automatic logic isProtected(input logic [7:0] sector);
        isProtected = (sector == `LPRS_PROT_SECTOR);
    endfunction

    // Release edge of the reset line
    assign resetRise = reset_line_n && !resetLineQ;
    // Sleep length, extended only when enabled
    assign sleepLimit = extSleepEn
        ? ((sleepCycles > DS_MAX_CYC) ? DS_MAX_CYC : sleepCycles)
        : ((sleepCycles > IDLE_CYC) ? IDLE_CYC : sleepCycles);

    // Next-state and output computation
    always_comb
    begin
        next_state = state;
        next_idleCount = idleCount;
        next_resetLineQ = reset_line_n;
        next_strapLatch = strapLatch;
        next_restoreMode = restoreMode;
        next_restoreBusy = 1'b0;
        next_restorePendingSet = restorePendingSet;
        tmrLoad = 1'b0;
        tmrValue = 32'h0000_0000;
        // Host flash port, factory sector refused
        next_grant = hostFlashReq && !isProtected(hostFlashSector);
        next_denied = hostFlashReq && isProtected(hostFlashSector);
        if (resetRise)
        begin
            // Straps caught once on reset release
            next_strapLatch = boot_strap_pins;
            if (boot_strap_pins == `LPRS_STRAP_RESTORE)
            begin
                next_restoreMode = restoreSel;
            end
            else
            begin
                next_restoreMode = lprs_pkg::RM_NONE;
            end
        end
        if (!reset_line_n)
        begin
            next_state = lprs_pkg::ST_BOOT;
        end
        else
        begin
            case (state)
                lprs_pkg::ST_BOOT:
                begin
                    if (resetRise)
                    begin
                        // Hold a cycle so the freshly latched mode is seen
                        next_state = lprs_pkg::ST_BOOT;
                    end
                    // Resume an unfinished restore after power loss, any straps
                    else if (restorePending || restorePendingSet)
                    begin
                        next_state = lprs_pkg::ST_RESTORE;
                        next_restorePendingSet = 1'b1;
                        tmrLoad = 1'b1;
                        tmrValue = RST_CYC;
                    end
                    else if (restoreMode != lprs_pkg::RM_NONE)
                    begin
                        next_state = lprs_pkg::ST_RESTORE;
                        next_restorePendingSet = 1'b1;
                        tmrLoad = 1'b1;
                        tmrValue = RST_CYC;
                    end
                    else
                    begin
                        next_state = lprs_pkg::ST_RUN;
                        next_idleCount = 32'h0000_0000;
                    end
                end
                lprs_pkg::ST_RESTORE:
                begin
                    next_restoreBusy = 1'b1;
                    if (tmrDone)
                    begin
                        next_restorePendingSet = 1'b0;
                        next_restoreMode = lprs_pkg::RM_NONE;
                        next_restoreBusy = 1'b0;
                        next_state = lprs_pkg::ST_RUN;
                        next_idleCount = 32'h0000_0000;
                    end
                end
                lprs_pkg::ST_RUN:
                begin
                    if (shutReq)
                    begin
                        next_state = lprs_pkg::ST_SHUT;
                    end
                    else if (hibReq)
                    begin
                        next_state = lprs_pkg::ST_HIB;
                    end
                    else if (activity || hostCmd)
                    begin
                        next_idleCount = 32'h0000_0000;
                    end
                    else if (idleCount >= IDLE_CYC - 1)
                    begin
                        // Enter sleep without any host exchange
                        next_state = lprs_pkg::ST_SLEEP;
                        tmrLoad = 1'b1;
                        tmrValue = (sleepLimit == 32'h0000_0000) ? 32'h0000_0001 : sleepLimit;
                    end
                    else
                    begin
                        next_idleCount = idleCount + 32'h0000_0001;
                    end
                end
                lprs_pkg::ST_SLEEP:
                begin
                    // Timer expiry or a host command wakes
                    if (tmrDone || hostCmd)
                    begin
                        next_state = lprs_pkg::ST_WAKE;
                        tmrLoad = 1'b1;
                        tmrValue = DS_WAKE_CYC;
                    end
                end
                lprs_pkg::ST_WAKE:
                begin
                    if (tmrDone)
                    begin
                        next_state = lprs_pkg::ST_RUN;
                        next_idleCount = 32'h0000_0000;
                    end
                end
                lprs_pkg::ST_HIB:
                begin
                    // Host wake line low leaves hibernate
                    if (!sleep_wake_line_n)
                    begin
                        next_state = lprs_pkg::ST_WAKE;
                        tmrLoad = 1'b1;
                        tmrValue = HIB_WAKE_CYC;
                    end
                end
                lprs_pkg::ST_SHUT:
                begin
                    // Power returns through a full wake
                    if (powerOn)
                    begin
                        next_state = lprs_pkg::ST_WAKE;
                        tmrLoad = 1'b1;
                        tmrValue = SHD_WAKE_CYC;
                    end
                end
                default:
                begin
                    next_state = lprs_pkg::ST_BOOT;
                end
            endcase
        end
        // Power domain outputs follow next state
        next_digitalPowerOn = !(next_state == lprs_pkg::ST_HIB ||
            next_state == lprs_pkg::ST_SHUT);
        next_rtcOn = (next_state != lprs_pkg::ST_SHUT);
        next_retainContext = (next_state == lprs_pkg::ST_SLEEP);
        next_ready = (next_state == lprs_pkg::ST_RUN);
    end

    // Register stage
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= lprs_pkg::ST_BOOT;
            idleCount <= 32'h0000_0000;
            resetLineQ <= 1'b0;
            strapLatch <= 3'h0;
            restoreMode <= lprs_pkg::RM_NONE;
            restoreBusy <= 1'b0;
            restorePendingSet <= 1'b0;
            digitalPowerOn <= 1'b1;
            rtcOn <= 1'b1;
            retainContext <= 1'b0;
            ready <= 1'b0;
            hostFlashGrant <= 1'b0;
            hostFlashDenied <= 1'b0;
            powerState <= 3'h0;
        end
        else
        begin
            state <= next_state;
            idleCount <= next_idleCount;
            resetLineQ <= next_resetLineQ;
            strapLatch <= next_strapLatch;
            restoreMode <= next_restoreMode;
            restoreBusy <= next_restoreBusy;
            restorePendingSet <= next_restorePendingSet;
            digitalPowerOn <= next_digitalPowerOn;
            rtcOn <= next_rtcOn;
            retainContext <= next_retainContext;
            ready <= next_ready;
            hostFlashGrant <= next_grant;
            hostFlashDenied <= next_denied;
            powerState <= next_state;
        end
    end
endmodule
`default_nettype wire

// ### sim/lprs_seq_sva.sv
// Checker for the sequencer ports
`timescale 1ns/10ps
`default_nettype none
module lprs_seq_sva #(
    parameter int unsigned IDLE_CYC = 10,
    parameter int unsigned RST_CYC = 50,
    parameter int unsigned DS_WAKE_CYC = 40,
    parameter int unsigned HIB_WAKE_CYC = 20,
    parameter int unsigned SHD_WAKE_CYC = 30
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic hostCmd,
    input wire logic activity,
    input wire logic hostFlashReq,
    input wire logic [7:0] hostFlashSector,
    input wire logic [2:0] powerState,
    input wire logic digitalPowerOn,
    input wire logic rtcOn,
    input wire logic retainContext,
    input wire logic ready,
    input wire logic hostFlashGrant,
    input wire logic hostFlashDenied
);
    localparam logic [2:0] S_RUN = lprs_pkg::ST_RUN;
    localparam logic [2:0] S_SLP = lprs_pkg::ST_SLEEP;
    // Longest of the three wake delays
    localparam int unsigned WAKE_A = (DS_WAKE_CYC > HIB_WAKE_CYC) ? DS_WAKE_CYC : HIB_WAKE_CYC;
    localparam int unsigned WAKE_MAX = (WAKE_A > SHD_WAKE_CYC) ? WAKE_A : SHD_WAKE_CYC;
    int unsigned wakeCnt; // Cycles in wake
    int unsigned resCnt; // Cycles restoring
    int unsigned idleCnt; // Quiet cycles in run
    int unsigned next_wakeCnt;
    int unsigned next_resCnt;
    int unsigned next_idleCnt;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Next counts
    always_comb
    begin
        next_wakeCnt = (powerState == lprs_pkg::ST_WAKE) ? wakeCnt + 1 : 0;
        next_resCnt = (powerState == lprs_pkg::ST_RESTORE) ? resCnt + 1 : 0;
        next_idleCnt = (powerState == S_RUN && !activity && !hostCmd) ? idleCnt + 1 : 0;
    end
    // Count registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wakeCnt <= 0;
            resCnt <= 0;
            idleCnt <= 0;
        end
        else
        begin
            wakeCnt <= next_wakeCnt;
            resCnt <= next_resCnt;
            idleCnt <= next_idleCnt;
        end
    end
    AST_IDLE_SLEEP: assert property (idleCnt <= IDLE_CYC + 2)
        else $error("idle run did not sleep");
    AST_CMD_WAKE: assert property (powerState == S_SLP && hostCmd |-> ##[1:2] powerState == 3'h3)
        else $error("command did not wake");
    AST_WAKE_TIME: assert property (wakeCnt <= WAKE_MAX + 1)
        else $error("wake too long");
    AST_READY_RUN: assert property (ready == (powerState == S_RUN))
        else $error("ready does not follow run");
    AST_SLEEP_KEEP: assert property (powerState == S_SLP |-> retainContext)
        else $error("context lost in sleep");
    AST_HIB_PWR: assert property (powerState == 3'h4 |-> !digitalPowerOn && rtcOn)
        else $error("hibernate power wrong");
    AST_SHUT_PWR: assert property (powerState == 3'h5 |-> !digitalPowerOn && !rtcOn)
        else $error("shutdown power wrong");
    AST_RESTORE_TIME: assert property (resCnt <= RST_CYC + 2)
        else $error("restore too long");
    AST_FLASH_DENY: assert property (powerState == S_RUN && hostFlashReq && hostFlashSector == 8'h00
        |=> hostFlashDenied && !hostFlashGrant)
        else $error("protected sector not denied");
    AST_FLASH_OK: assert property (powerState == S_RUN && hostFlashReq && hostFlashSector != 8'h00
        |=> hostFlashGrant && !hostFlashDenied)
        else $error("sector not granted");
endmodule
bind lprs_sequencer lprs_seq_sva #(.IDLE_CYC(IDLE_CYC), .RST_CYC(RST_CYC),
    .DS_WAKE_CYC(DS_WAKE_CYC), .HIB_WAKE_CYC(HIB_WAKE_CYC), .SHD_WAKE_CYC(SHD_WAKE_CYC))
    lprs_seq_sva_i (
    .clk_sys, .arst_n, .hostCmd, .activity, .hostFlashReq, .hostFlashSector, .powerState,
    .digitalPowerOn, .rtcOn, .retainContext, .ready, .hostFlashGrant, .hostFlashDenied);
`default_nettype wire

// ### sim/lprs_host_model.sv
// Host model driving reset, wake and strap pins
`timescale 1ns/10ps
`default_nettype none
module lprs_host_model (
    input wire logic clk_sys,
    output logic reset_line_n,
    output logic sleep_wake_line_n,
    output logic [2:0] boot_strap_pins,
    output logic hostCmd
);
    // Idle levels
    initial
    begin
        reset_line_n = 1'b1;
        sleep_wake_line_n = 1'b1;
        boot_strap_pins = 3'b000;
        hostCmd = 1'b0;
    end
    // Straps held across the reset release, then changed
    task automatic boot(input logic [2:0] straps);
        @(negedge clk_sys);
        boot_strap_pins = straps;
        reset_line_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        reset_line_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        boot_strap_pins = ~straps;
    endtask
    // Wake line low for three cycles
    task automatic wake_hib();
        sleep_wake_line_n = 1'b0;
        repeat (3) @(negedge clk_sys);
        sleep_wake_line_n = 1'b1;
    endtask
    // One-cycle command, no handshake
    task automatic command();
        hostCmd = 1'b1;
        @(negedge clk_sys);
        hostCmd = 1'b0;
    endtask
endmodule
`default_nettype wire

// ### sim/low_power_and_restore_sequencer_tb.sv
// Testbench for the sequencer
`timescale 1ns/10ps
`default_nettype none
module low_power_and_restore_sequencer_tb;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic rl, wl, hc, activity, extSleepEn, hibReq, shutReq, powerOn, restorePending;
    logic hostFlashReq;
    logic [2:0] straps, powerState;
    logic [1:0] restoreSel, restoreMode;
    logic [7:0] sec;
    logic [31:0] sleepCycles, seed, p;
    logic dpo, rtcOn, retainContext, ready, busy, pendSet, grant, denied;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;
    int k; // Cycles spent asleep
    always #12.5 clk_sys = ~clk_sys;
    lprs_sequencer #(.IDLE_CYC(10), .DS_MAX_CYC(100), .HIB_WAKE_CYC(20), .SHD_WAKE_CYC(30),
        .RST_CYC(50), .DS_WAKE_CYC(40)) lprs_sequencer_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .reset_line_n(rl),
        .sleep_wake_line_n(wl), .boot_strap_pins(straps), .hostCmd(hc), .activity(activity),
        .extSleepEn(extSleepEn), .sleepCycles(sleepCycles), .hibReq(hibReq), .shutReq(shutReq),
        .powerOn(powerOn), .restoreSel(restoreSel), .restorePending(restorePending),
        .hostFlashReq(hostFlashReq), .hostFlashSector(sec), .powerState(powerState),
        .digitalPowerOn(dpo), .rtcOn(rtcOn), .retainContext(retainContext), .ready(ready),
        .restoreBusy(busy), .restorePendingSet(pendSet), .restoreMode(restoreMode),
        .hostFlashGrant(grant), .hostFlashDenied(denied));
    lprs_host_model lprs_host_model_i (.clk_sys(clk_sys), .reset_line_n(rl),
        .sleep_wake_line_n(wl), .boot_strap_pins(straps), .hostCmd(hc));
    // Compare one value
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Expected sleep length: clamp to idle limit 10 or extended limit 100, zero runs one cycle
    function automatic logic [7:0] sleep_len(input logic ext, input logic [31:0] req);
        logic [31:0] lim;
        lim = ext ? 32'h0000_0064 : 32'h0000_000a;
        if (req == 32'h0000_0000)
            sleep_len = 8'h01;
        else
            sleep_len = (req > lim) ? lim[7:0] : req[7:0];
    endfunction
    // Wait for a state within a budget
    task automatic wait_state(input logic [2:0] st, input int lim);
        int n;
        n = 0;
        while (powerState !== st && n <= lim)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("state", {5'h00, st}, {5'h00, powerState});
    endtask
    // Counts and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_mismatch++;
            stop_test();
        end
    end
    initial
    begin
        seed = 32'hd263_3bc5;
        {activity, extSleepEn, hibReq, shutReq, powerOn, restorePending, hostFlashReq} = 7'h40;
        {restoreSel, sec, sleepCycles} = '0;
        repeat (16) @(negedge clk_sys);
        check("dpo", 8'h01, {7'h00, dpo});
        arst_n = 1'b1;
        wait_state(lprs_pkg::ST_RUN, 4);
        for (int m = 0; m < 3; m++)
        begin
            restoreSel = m[1:0];
            lprs_host_model_i.boot(3'b110);
            check("mode", {6'h00, m[1:0]}, {6'h00, restoreMode});
            if (m != 0)
                check("pend", 8'h01, {7'h00, pendSet});
            wait_state(lprs_pkg::ST_RUN, 54);
            $display("restore mode %0d done", m);
        end
        for (int i = 0; i < 4; i++)
        begin
            p = $random(seed);
            lprs_host_model_i.boot(p[2:0] == 3'b110 ? 3'b111 : p[2:0]);
            check("state", {5'h00, lprs_pkg::ST_RUN}, {5'h00, powerState});
            check("mode", 8'h00, {6'h00, restoreMode});
        end
        restorePending = 1'b1;
        lprs_host_model_i.boot(3'b000);
        wait_state(lprs_pkg::ST_RESTORE, 2);
        @(negedge clk_sys);
        check("busy", 8'h01, {7'h00, busy});
        restorePending = 1'b0;
        wait_state(lprs_pkg::ST_RUN, 54);
        for (int i = 0; i < 24; i++)
        begin
            p = $random(seed);
            sec = p[0] ? 8'h00 : p[15:8];
            hostFlashReq = p[16] | (i < 4);
            @(negedge clk_sys);
            check("deny", {7'h00, hostFlashReq && sec == 8'h00}, {7'h00, denied});
            check("grant", {7'h00, hostFlashReq && sec != 8'h00}, {7'h00, grant});
        end
        hostFlashReq = 1'b0;
        $display("flash test done");
        hibReq = 1'b1;
        wait_state(lprs_pkg::ST_HIB, 4);
        check("dpo", 8'h00, {7'h00, dpo});
        hibReq = 1'b0;
        check("rtc", 8'h01, {7'h00, rtcOn});
        lprs_host_model_i.wake_hib();
        wait_state(lprs_pkg::ST_RUN, 24);
        shutReq = 1'b1;
        wait_state(lprs_pkg::ST_SHUT, 4);
        shutReq = 1'b0;
        check("rtc", 8'h00, {7'h00, rtcOn});
        powerOn = 1'b1;
        wait_state(lprs_pkg::ST_WAKE, 4);
        powerOn = 1'b0;
        wait_state(lprs_pkg::ST_RUN, 34);
        $display("hibernate and shutdown done");
        extSleepEn = 1'b1;
        sleepCycles = $random(seed);
        activity = 1'b0;
        wait_state(lprs_pkg::ST_SLEEP, 14);
        activity = 1'b1;
        check("keep", 8'h01, {7'h00, retainContext});
        lprs_host_model_i.command();
        wait_state(lprs_pkg::ST_WAKE, 4);
        wait_state(lprs_pkg::ST_RUN, 44);
        check("ready", 8'h01, {7'h00, ready});
        // Timer wakes, length clamped by the extended-sleep setting
        for (int j = 0; j < 3; j++)
        begin
            p = $random(seed);
            extSleepEn = (j == 0) ? 1'b1 : p[0];
            sleepCycles = (j == 0) ? 32'h0000_0000 : {25'h000_0000, p[14:8]};
            activity = 1'b0;
            wait_state(lprs_pkg::ST_SLEEP, 14);
            k = 0;
            while (powerState === lprs_pkg::ST_SLEEP && k < 200)
            begin
                @(negedge clk_sys);
                k++;
            end
            check("sleep", sleep_len(extSleepEn, sleepCycles) + 8'h01, k[7:0]);
            activity = 1'b1;
            wait_state(lprs_pkg::ST_RUN, 44);
        end
        $display("deep sleep done");
        stop_test();
    end
endmodule
`default_nettype wire
